/* design/rcl_config_decoder.sv */
// Purpose: holds four configuration latch bytes and decodes them
// Assumes: software writes the latches; outputs follow at each reset
// Notes: decoded outputs are frozen outside reset; rdata is not
//
// Behaviour
// - Four latch bytes configure device at reset
// - Two-bit code picks port reset drive
// - One drive mode covers all port pins
// - Bit chooses general pin or external reset
// - Debug access blocked at zero, allowed at one
// - Two-bit code selects debug interface
// - Bit selects ECC or data flash use
// - Four-bit digital clock phase delay output
module rcl_config_decoder #(
    // Package dependent default of the reset pin bit
    parameter logic EXT_RESET_DEFAULT = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [rcl_pkg::ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Decoded port reset drive modes, ports 0-6, 12, 15
    output logic [17:0] port_reset_drive_mode,
    // Drive enables of port 0 pins
    output logic [7:0] port0_pin_analog,
    output logic [7:0] port0_pin_digital,
    output logic [7:0] port0_pin_pull_up,
    output logic [7:0] port0_pin_pull_down,
    // Reset pin, debug, flash and clock settings
    output logic ext_reset_pin_enable,
    output logic debug_access_enable,
    output logic [1:0] debug_port_select,
    output logic jtag5_on,
    output logic jtag4_on,
    output logic swd_on,
    output logic ecc_region_enable,
    output logic [3:0] digital_clock_phase_delay
);
    // ----------------------------------------------------------------
    // Latch array
    // ----------------------------------------------------------------
    // Nonvolatile latch bytes, factory values present from power up
    logic [7:0] config_latch [0:3] = '{
        rcl_pkg::LOW_RESET,
        rcl_pkg::HIGH_RESET,
        rcl_pkg::RESET_DEBUG_RESET | {EXT_RESET_DEFAULT, 7'h00},
        rcl_pkg::ECC_DEBUG_CLOCK_RESET
    };
    logic capture_seen; // Outputs still match the latch bytes
    logic [3:0] idx; // Register index of the access
    logic addr_ok; // Address inside the register window

    // Register index from the low address bits
    function automatic logic [3:0] word_idx(
        input logic [rcl_pkg::ADDR_W-1:0] a);
        word_idx = a[3:0];
    endfunction

    assign idx = word_idx(addr);
    assign addr_ok = (addr[5:4] == 2'h0) && (idx <= rcl_pkg::STATUS_IDX);

    // Latch contents survive reset; a write updates one byte
    always_ff @(posedge clk) begin
        if (wr && addr_ok && idx < rcl_pkg::STATUS_IDX) begin
            config_latch[idx[1:0]] <= wdata;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Read data one cycle after strobe; unmapped reads zero
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (rd && addr_ok) begin
            if (idx == rcl_pkg::STATUS_IDX) begin
                rdata <= {6'h00, capture_seen, debug_access_enable};
            end else begin
                rdata <= config_latch[idx[1:0]];
            end
        end else begin
            rdata <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Capture during reset
    // ----------------------------------------------------------------
    // Set by every capture, cleared when a latch byte is rewritten;
    // a write in reset is picked up by the next capture edge
    always_ff @(posedge clk) begin
        if (rst) begin
            capture_seen <= 1'b1;
        end else if (wr && addr_ok && idx < rcl_pkg::STATUS_IDX) begin
            capture_seen <= 1'b0;
        end
    end

    // Port drive modes in bit pairs from bytes 0, 1 and 2
    always_ff @(posedge clk) begin
        if (rst) begin
            port_reset_drive_mode <= {config_latch[2][1:0],
                config_latch[1], config_latch[0]};
        end
    end

    // Single bit settings, debug port code and phase delay from byte 2 and byte 3
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_reset_pin_enable <=
                config_latch[2][rcl_pkg::EXT_RESET_BIT];
            debug_access_enable <=
                config_latch[2][rcl_pkg::DEBUG_EN_BIT];
            ecc_region_enable <=
                config_latch[3][rcl_pkg::ECC_EN_BIT];
            digital_clock_phase_delay <=
                config_latch[3][rcl_pkg::PHASE_LSB +: 4];
            debug_port_select <= config_latch[3][rcl_pkg::DPS_LSB +: 2];
        end
    end

    // Debug interface enables, all off when access is blocked
    always_ff @(posedge clk) begin
        if (rst) begin
            jtag5_on <= config_latch[2][rcl_pkg::DEBUG_EN_BIT] &&
                config_latch[3][1:0] == rcl_pkg::DBG_JTAG5;
            jtag4_on <= config_latch[2][rcl_pkg::DEBUG_EN_BIT] &&
                config_latch[3][1:0] == rcl_pkg::DBG_JTAG4;
            swd_on <= config_latch[2][rcl_pkg::DEBUG_EN_BIT] &&
                config_latch[3][1:0] == rcl_pkg::DBG_SWD;
        end
    end

    // ----------------------------------------------------------------
    // Pin expansion of port 0
    // ----------------------------------------------------------------
    rcl_port_expand u_port0 (
        .clk(clk),
        .rst(rst),
        .load(1'b1),
        .mode(config_latch[0][1:0]),
        .pin_analog(port0_pin_analog),
        .pin_digital(port0_pin_digital),
        .pin_pull_up(port0_pin_pull_up),
        .pin_pull_down(port0_pin_pull_down)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_hold;
        @(posedge clk) !rst |=> $stable(port_reset_drive_mode);
    endproperty
    a_hold: assert property (p_hold) else $error("drive mode moved");

    property p_cap;
        @(posedge clk) rst |=>
            port_reset_drive_mode[1:0] == $past(config_latch[0][1:0]);
    endproperty
    a_cap: assert property (p_cap) else $error("port0 not captured");

    property p_ext;
        @(posedge clk) rst |=>
            ext_reset_pin_enable == $past(config_latch[2][7]);
    endproperty
    a_ext: assert property (p_ext) else $error("reset pin bit");

    property p_dbg;
        @(posedge clk) disable iff (rst) !debug_access_enable |->
            !(jtag4_on || jtag5_on || swd_on);
    endproperty
    a_dbg: assert property (p_dbg) else $error("debug not blocked");

    property p_dps;
        @(posedge clk) disable iff (rst)
            debug_port_select == rcl_pkg::DBG_NONE |->
            !(jtag4_on || jtag5_on || swd_on);
    endproperty
    a_dps: assert property (p_dps) else $error("ports not off");

    property p_ecc;
        @(posedge clk) rst |=> ecc_region_enable == $past(config_latch[3][2]);
    endproperty
    a_ecc: assert property (p_ecc) else $error("ecc bit");

    property p_phs;
        @(posedge clk) rst |=>
            digital_clock_phase_delay == $past(config_latch[3][6:3]);
    endproperty
    a_phs: assert property (p_phs) else $error("phase delay");

    property p_uni;
        @(posedge clk) rst ##1 rst |=> port0_pin_pull_up == {8{
            port_reset_drive_mode[1:0] == rcl_pkg::DRIVE_PULL_UP}};
    endproperty
    a_uni: assert property (p_uni) else $error("pins differ");

    property p_p15;
        @(posedge clk) rst |=>
            port_reset_drive_mode[17:16] == $past(config_latch[2][1:0]);
    endproperty
    a_p15: assert property (p_p15) else $error("port15 field");

    property p_wr;
        @(posedge clk) wr && addr_ok && idx == 4'h1 |=>
            config_latch[1] == $past(wdata);
    endproperty
    a_wr: assert property (p_wr) else $error("latch write lost");

    // ----------------------------------------------------------------
    // Capture, read-back and hold checks
    // ----------------------------------------------------------------
    // Debug access bit taken from byte 2 at each capture
    property p_dbg_cap;
        @(posedge clk) rst |=> debug_access_enable ==
            $past(config_latch[2][rcl_pkg::DEBUG_EN_BIT]);
    endproperty
    a_dbg_cap: assert property (p_dbg_cap) else $error("debug bit");

    // Debug port code taken from byte 3 at each capture
    property p_dsel_cap;
        @(posedge clk) rst |=> debug_port_select ==
            $past(config_latch[3][rcl_pkg::DPS_LSB +: 2]);
    endproperty
    a_dsel_cap: assert property (p_dsel_cap) else $error("port code");

    // Five-wire interface only when chosen and access allowed
    property p_jt5;
        @(posedge clk) rst |=> jtag5_on ==
            ($past(config_latch[2][rcl_pkg::DEBUG_EN_BIT]) &&
            $past(config_latch[3][1:0]) == rcl_pkg::DBG_JTAG5);
    endproperty
    a_jt5: assert property (p_jt5) else $error("jtag5 enable");

    // Four-wire interface only when chosen and access allowed
    property p_jt4;
        @(posedge clk) rst |=> jtag4_on ==
            ($past(config_latch[2][rcl_pkg::DEBUG_EN_BIT]) &&
            $past(config_latch[3][1:0]) == rcl_pkg::DBG_JTAG4);
    endproperty
    a_jt4: assert property (p_jt4) else $error("jtag4 enable");

    // Serial wire interface only when chosen and access allowed
    property p_swd;
        @(posedge clk) rst |=> swd_on ==
            ($past(config_latch[2][rcl_pkg::DEBUG_EN_BIT]) &&
            $past(config_latch[3][1:0]) == rcl_pkg::DBG_SWD);
    endproperty
    a_swd: assert property (p_swd) else $error("swd enable");

    // Ports 0 to 3 come from byte 0 in successive pairs
    property p_low;
        @(posedge clk) rst |=> port_reset_drive_mode[7:0] ==
            $past(config_latch[0]);
    endproperty
    a_low: assert property (p_low) else $error("byte 0 layout");

    // Ports 4, 5, 6 and 12 come from byte 1 in successive pairs
    property p_high;
        @(posedge clk) rst |=> port_reset_drive_mode[15:8] ==
            $past(config_latch[1]);
    endproperty
    a_high: assert property (p_high) else $error("byte 1 layout");

    // Pin 0 of port 0 has exactly one drive mode after capture
    property p_one;
        @(posedge clk) disable iff (rst) $onehot({port0_pin_analog[0],
            port0_pin_digital[0], port0_pin_pull_up[0],
            port0_pin_pull_down[0]});
    endproperty
    a_one: assert property (p_one) else $error("mode not one-hot");

    // All eight pins of port 0 carry the same analog and pull-down enables
    property p_same;
        @(posedge clk) disable iff (rst)
            port0_pin_analog == {8{port0_pin_analog[0]}} &&
            port0_pin_pull_down == {8{port0_pin_pull_down[0]}};
    endproperty
    a_same: assert property (p_same) else $error("pins not uniform");

    // A read of byte 2 returns the latch one cycle later
    property p_rd;
        @(posedge clk) !rst && rd && addr_ok &&
            idx == rcl_pkg::RESET_DEBUG_CFG_IDX |=>
            rdata == $past(config_latch[2]);
    endproperty
    a_rd: assert property (p_rd) else $error("read data");

    // Read data stand for one cycle only, zero otherwise
    property p_idle;
        @(posedge clk) !rd |=> rdata == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("read data idle");

    // Every capture marks the outputs as current
    property p_seen;
        @(posedge clk) rst |=> capture_seen;
    endproperty
    a_seen: assert property (p_seen) else $error("capture flag");

    // A latch write outside reset marks the outputs as stale
    property p_stale;
        @(posedge clk) !rst && wr && addr_ok &&
            idx < rcl_pkg::STATUS_IDX |=> !capture_seen;
    endproperty
    a_stale: assert property (p_stale) else $error("stale flag");

    // Reset pin, debug, ECC and phase settings and pull-up enables frozen outside reset
    property p_held;
        @(posedge clk) !rst |=> $stable({ext_reset_pin_enable,
            debug_access_enable, debug_port_select, ecc_region_enable,
            digital_clock_phase_delay, port0_pin_pull_up});
    endproperty
    a_held: assert property (p_held) else $error("settings moved");

    c_jt5: cover property (@(posedge clk) !rst && jtag5_on);
    c_swd: cover property (@(posedge clk) !rst && swd_on);
    c_pull: cover property (@(posedge clk) !rst && port0_pin_pull_down[0]);
    c_ext: cover property (@(posedge clk) !rst && ext_reset_pin_enable);
endmodule

/* pkg/rcl_pkg.sv */
// Purpose: constants for the configuration latch decoder
// Assumes: four byte-wide latches at offsets 0 to 3, status at 4
// Notes: the register offset equals the latch index
package rcl_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [3:0] PORT_DRIVE_CFG_LOW_IDX = 4'h0;
    localparam logic [3:0] PORT_DRIVE_CFG_HIGH_IDX = 4'h1;
    localparam logic [3:0] RESET_DEBUG_CFG_IDX = 4'h2;
    localparam logic [3:0] ECC_DEBUG_CLOCK_CFG_IDX = 4'h3;
    localparam logic [3:0] STATUS_IDX = 4'h4;
    localparam int ADDR_W = 6;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int EXT_RESET_BIT = 7;
    localparam int DEBUG_EN_BIT = 6;
    localparam int ECC_EN_BIT = 2;
    localparam int DPS_LSB = 0;
    localparam int PHASE_LSB = 3;
    // ----------------------------------------------------------------
    // Factory defaults
    // ----------------------------------------------------------------
    localparam logic [7:0] LOW_RESET = 8'h00;
    localparam logic [7:0] HIGH_RESET = 8'h00;
    localparam logic [7:0] RESET_DEBUG_RESET = 8'h40;
    localparam logic [7:0] ECC_DEBUG_CLOCK_RESET = 8'h05;
    // ----------------------------------------------------------------
    // Drive modes and debug port choices
    // ----------------------------------------------------------------
    localparam logic [1:0] DRIVE_HIZ_ANALOG = 2'h0;
    localparam logic [1:0] DRIVE_HIZ_DIGITAL = 2'h1;
    localparam logic [1:0] DRIVE_PULL_UP = 2'h2;
    localparam logic [1:0] DRIVE_PULL_DOWN = 2'h3;
    localparam logic [1:0] DBG_JTAG5 = 2'h0;
    localparam logic [1:0] DBG_JTAG4 = 2'h1;
    localparam logic [1:0] DBG_SWD = 2'h2;
    localparam logic [1:0] DBG_NONE = 2'h3;
    localparam int NUM_PORTS = 9;
endpackage

/* design/rcl_port_expand.sv */
// Purpose: spreads one drive mode code over every pin of a port
// Assumes: eight pins per port
// Notes: decoded as four one-hot pin enables per pin
module rcl_port_expand (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Capture strobe and code
    input wire logic load,
    input wire logic [1:0] mode,
    // Per-pin drive enables
    output logic [7:0] pin_analog,
    output logic [7:0] pin_digital,
    output logic [7:0] pin_pull_up,
    output logic [7:0] pin_pull_down
);
    // Replicate the decoded mode to all eight pins on capture
    always_ff @(posedge clk) begin
        if (rst && load) begin
            pin_analog <= {8{mode == rcl_pkg::DRIVE_HIZ_ANALOG}};
            pin_digital <= {8{mode == rcl_pkg::DRIVE_HIZ_DIGITAL}};
            pin_pull_up <= {8{mode == rcl_pkg::DRIVE_PULL_UP}};
            pin_pull_down <= {8{mode == rcl_pkg::DRIVE_PULL_DOWN}};
        end
    end
endmodule

/* sim/reset_config_latch_decoder_tb_top.sv */
// Purpose: self-checking bench for the configuration latch decoder
// Assumes: latch n at offset n, status at offset 4, rdata one cycle
// Notes: latches survive reset, so each pattern is written then reset
module reset_config_latch_decoder_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1; // Held for the first six cycles
    logic [rcl_pkg::ADDR_W-1:0] addr = '0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [17:0] drive;
    logic [7:0] p_an, p_dg, p_pu, p_pd;
    logic ext_en, dbg_en, jt5, jt4, swd, ecc_en;
    logic [1:0] dsel;
    logic [3:0] phase;
    int fails = 0;
    int num_checks = 0;
    // ----------------------------------------------------------------
    // Clock, device and watchdog
    // ----------------------------------------------------------------
    initial begin
        forever #12.5 clk = ~clk;
    end
    rcl_config_decoder i_dut (.clk(clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .port_reset_drive_mode(drive), .port0_pin_analog(p_an),
        .port0_pin_digital(p_dg), .port0_pin_pull_up(p_pu),
        .port0_pin_pull_down(p_pd), .ext_reset_pin_enable(ext_en),
        .debug_access_enable(dbg_en), .debug_port_select(dsel),
        .jtag5_on(jt5), .jtag4_on(jt4), .swd_on(swd),
        .ecc_region_enable(ecc_en), .digital_clock_phase_delay(phase));
    // Cuts a hang short well beyond the 165 or so cycles needed
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        stop_test();
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    // Compares one value and reports a mismatch at once
    task automatic chk(input string nm, input logic [17:0] e,
        input logic [17:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One-cycle write strobe
    task automatic wr_b(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // One-cycle read strobe, data sampled in the following cycle only
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rdata", {10'h000, e}, {10'h000, rdata});
    endtask
    // Reset held for five cycles, outputs looked at after release
    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    // Prints the counts and the verdict, then ends the run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        logic [1:0] m;
        logic [7:0] b0, b1, b2, b3;
        do_reset();
        // Factory values of all four latches and their decode
        chk("drive", 18'h00000, drive);
        chk("ext", 18'(rcl_pkg::RESET_DEBUG_RESET[7]), 18'(ext_en));
        chk("dbg", 18'h1, 18'(dbg_en));
        chk("dsel", 18'(rcl_pkg::DBG_JTAG4), 18'(dsel));
        chk("jt4", 18'h1, 18'(jt4));
        chk("ecc", 18'h1, 18'(ecc_en));
        rd_chk(6'h02, rcl_pkg::RESET_DEBUG_RESET);
        rd_chk(6'h03, rcl_pkg::ECC_DEBUG_CLOCK_RESET);
        rd_chk(6'h04, 8'h03);
        // Refused accesses: aliases above the window and a status write
        wr_b(6'h21, 8'hff);
        wr_b(6'h04, 8'hff);
        rd_chk(6'h00, 8'h00);
        rd_chk(6'h01, 8'h00);
        rd_chk(6'h22, 8'h00);
        rd_chk(6'h04, 8'h03);
        // Every drive mode and debug choice; the fifth pass blocks debug
        for (int i = 0; i < 5; i++) begin
            m = i[1:0];
            b0 = {4{m}} ^ 8'he4;
            b1 = {4{m}} ^ 8'h1b;
            b2 = {m[1], i != 4, 4'h0, ~m};
            b3 = {1'b0, ~m, m, m[1], m};
            wr_b(6'h00, b0);
            wr_b(6'h01, b1);
            wr_b(6'h02, b2);
            wr_b(6'h03, b3);
            rd_chk(6'h01, b1);
            rd_chk(6'h03, b3);
            do_reset();
            chk("drive", {b2[1:0], b1, b0}, drive);
            chk("an", {10'h0, {8{m == 2'h0}}}, {10'h0, p_an});
            chk("dg", {10'h0, {8{m == 2'h1}}}, {10'h0, p_dg});
            chk("pu", {10'h0, {8{m == 2'h2}}}, {10'h0, p_pu});
            chk("pd", {10'h0, {8{m == 2'h3}}}, {10'h0, p_pd});
            chk("ext", 18'(b2[7]), 18'(ext_en));
            chk("dbg", 18'(b2[6]), 18'(dbg_en));
            chk("dsel", 18'(b3[1:0]), 18'(dsel));
            chk("jt5", 18'(b2[6] && m == 2'h0), 18'(jt5));
            chk("jt4", 18'(b2[6] && m == 2'h1), 18'(jt4));
            chk("swd", 18'(b2[6] && m == 2'h2), 18'(swd));
            chk("ecc", 18'(b3[2]), 18'(ecc_en));
            chk("phase", 18'(b3[6:3]), 18'(phase));
            // New latch values must not reach the outputs before reset
            wr_b(6'h00, ~b0);
            wr_b(6'h03, ~b3);
            rd_chk(6'h04, {6'h00, 1'b0, b2[6]});
            repeat (3) @(posedge clk);
            #1;
            chk("held", {b2[1:0], b1, b0}, drive);
            chk("held_ph", 18'(b3[6:3]), 18'(phase));
        end
        stop_test();
    end
endmodule
